// ===== hw/tmr_pkg.sv
// Constants, register map and field layout of the 16-bit timer/counter
package tmr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
   localparam logic [7:0] IDX_COUNT_LOW_BYTE = 8'h0E;
   localparam logic [7:0] IDX_COUNT_HIGH_BYTE = 8'h0F;
   localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
   // Reset values
   localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_FLAGS = 8'h00;
   localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_ENABLES = 8'h00;
   // Timer control fields
   localparam int TIMER_ON_BIT = 0;
   localparam int CLOCK_SOURCE_SELECT_BIT = 1;
   localparam int SYNC_DISABLE_N_BIT = 2;
   localparam int LOW_FREQ_OSC_ENABLE_BIT = 3;
   localparam int PRESCALE_SELECT_LO_BIT = 4;
   localparam int PRESCALE_SELECT_HI_BIT = 5;
   localparam logic [7:0] TIMER_CONTROL_MASK = 8'h3F;
   // Flag, enable and interrupt control fields
   localparam int OVERFLOW_FLAG_BIT = 0;
   localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
   localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
   localparam int PERIPH_IRQ_ENABLE_BIT = 6;
   // Compare mode code that requests the special event trigger
   localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;
   // Clock and instruction cycle
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int PHASES_PER_CYCLE = 4;
   localparam logic [1:0] SECOND_PHASE = 2'h1;
   localparam logic [1:0] FOURTH_PHASE = 2'h3;
   // Counter limits
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage : tmr_pkg

// ===== hw/two_flop_sync.sv
// Two-stage level synchronizer for pins entering the core clock
`timescale 1ns/1ps
module two_flop_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      meta_r <= async_in;
      sync_out <= meta_r;
   end
endmodule : two_flop_sync

// ===== hw/ripple_prescaler.sv
// Edge prescaler dividing the selected count source by 1, 2, 4 or 8
`timescale 1ns/1ps
module ripple_prescaler #(
   parameter int STAGES = 3
) (
   input wire logic clock,
   input wire logic clear,
   input wire logic src_level,
   input wire logic [1:0] select,
   output logic presc_out
);
   logic src_prev_r;
   logic [STAGES-1:0] stage_r;

   // Advance on each rising edge of the source; clear wins
   always_ff @(posedge clock) begin
      src_prev_r <= src_level;
      if (clear) begin
         stage_r <= '0;
      end else if (src_level && !src_prev_r) begin
         stage_r <= stage_r + 1'b1;
      end
   end

   // Each stage toggles at half the rate below: symmetric output
   always_comb begin
      case (select)
         2'h0: presc_out = src_level;
         2'h1: presc_out = stage_r[0];
         2'h2: presc_out = stage_r[1];
         2'h3: presc_out = stage_r[2];
         default: presc_out = src_level;
      endcase
   end
endmodule : ripple_prescaler

// ===== hw/timer_counter.sv
// 16-bit timer/counter with APB register access
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module sixteen_bit_timer_counter #(
   parameter int ADDR_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic dev_reset,
   input wire logic sleep,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_input,
   input wire logic osc_in_pin,
   output logic osc_out_pin,
   input wire logic [3:0] compare_mode_select_one,
   input wire logic compare_match_one,
   input wire logic [3:0] compare_mode_select_two,
   input wire logic compare_match_two,
   output logic [15:0] timebase,
   output logic timebase_valid,
   output logic overflow_irq,
   output logic wake_request
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0] interrupt_control_r;
   logic [7:0] peripheral_flags_r;
   logic [7:0] peripheral_enables_r;
   logic [7:0] timer_control_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [1:0] phase_r;
   logic [1:0] pins_s;
   logic presc_out;
   logic presc_clear;
   logic presc_prev_r;
   logic sample_r;
   logic sync_rise_r;
   logic osc_drive_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic irq_r;
   logic wake_r;
   logic tb_valid_r;

   logic [7:0] reg_index;
   logic access_go;
   logic wr_fire;
   logic wr_lane0;
   logic [7:0] wr_byte;
   logic wr_count_lo;
   logic wr_count_hi;
   logic wr_count_any;
   logic mapped;
   logic [7:0] rd_byte;

   logic timer_on;
   logic ext_mode;
   logic async_mode;
   logic sync_mode;
   logic osc_en;
   logic [1:0] presc_sel;
   logic src_level;
   logic sample_phase;
   logic inc_timer;
   logic inc_sync;
   logic inc_async;
   logic inc;
   logic trigger_hit;
   logic overflow_set;

   ////////////////////////////////////////////////////////////////////
   // APB decode

   // One wait cycle in the access phase gives read data a full clock
   assign reg_index = paddr[9:2];
   assign access_go = psel && penable && !pready_r;
   assign wr_fire = psel && penable && pready_r && pwrite;
   assign wr_lane0 = wr_fire && pstrb[0] && mapped;
   assign wr_byte = pwdata[7:0];
   assign wr_count_lo =
      wr_lane0 && (reg_index == tmr_pkg::IDX_COUNT_LOW_BYTE);
   assign wr_count_hi =
      wr_lane0 && (reg_index == tmr_pkg::IDX_COUNT_HIGH_BYTE);
   assign wr_count_any = wr_count_lo || wr_count_hi;

   // Read mux; unmapped addresses read zero and flag an error
   always_comb begin
      mapped = 1'b1;
      rd_byte = 8'h00;
      case (reg_index)
         tmr_pkg::IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control_r;
         tmr_pkg::IDX_PERIPHERAL_FLAGS: rd_byte = peripheral_flags_r;
         tmr_pkg::IDX_COUNT_LOW_BYTE: rd_byte = count_r[7:0];
         tmr_pkg::IDX_COUNT_HIGH_BYTE: rd_byte = count_r[15:8];
         tmr_pkg::IDX_TIMER_CONTROL: rd_byte = timer_control_r;
         tmr_pkg::IDX_PERIPHERAL_ENABLES: rd_byte = peripheral_enables_r;
         default: mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0) begin
         mapped = 1'b0;
         rd_byte = 8'h00;
      end
   end

   // Ready, read data and error are registered
   always_ff @(posedge clock) begin
      if (rst) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= access_go;
         if (access_go) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
            pslverr_r <= !mapped;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control registers

   // Control clears on power-on/brown-out only; device reset keeps it
   always_ff @(posedge clock) begin
      if (rst) begin
         timer_control_r <= tmr_pkg::RST_TIMER_CONTROL;
      end else if (wr_lane0 &&
                   reg_index == tmr_pkg::IDX_TIMER_CONTROL) begin
         timer_control_r <= wr_byte & tmr_pkg::TIMER_CONTROL_MASK;
      end
   end

   // Interrupt control and enables are plain storage
   always_ff @(posedge clock) begin
      if (rst) begin
         interrupt_control_r <= tmr_pkg::RST_INTERRUPT_CONTROL;
         peripheral_enables_r <= tmr_pkg::RST_PERIPHERAL_ENABLES;
      end else begin
         if (wr_lane0 && reg_index == tmr_pkg::IDX_INTERRUPT_CONTROL) begin
            interrupt_control_r <= wr_byte;
         end
         if (wr_lane0 && reg_index == tmr_pkg::IDX_PERIPHERAL_ENABLES) begin
            peripheral_enables_r <= wr_byte;
         end
      end
   end

   // Field aliases
   assign timer_on = timer_control_r[tmr_pkg::TIMER_ON_BIT];
   assign ext_mode = timer_control_r[tmr_pkg::CLOCK_SOURCE_SELECT_BIT];
   assign osc_en = timer_control_r[tmr_pkg::LOW_FREQ_OSC_ENABLE_BIT];
   assign presc_sel = {timer_control_r[tmr_pkg::PRESCALE_SELECT_HI_BIT],
                       timer_control_r[tmr_pkg::PRESCALE_SELECT_LO_BIT]};
   // Sync disable means nothing in timer mode
   assign async_mode =
      ext_mode && timer_control_r[tmr_pkg::SYNC_DISABLE_N_BIT];
   assign sync_mode =
      ext_mode && !timer_control_r[tmr_pkg::SYNC_DISABLE_N_BIT];

   ////////////////////////////////////////////////////////////////////
   // Instruction phase clocks

   // Four core clocks per instruction cycle; frozen while asleep
   always_ff @(posedge clock) begin
      if (rst || dev_reset) begin
         phase_r <= 2'h0;
      end else if (!sleep) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   assign sample_phase = (phase_r == tmr_pkg::SECOND_PHASE) ||
                         (phase_r == tmr_pkg::FOURTH_PHASE);

   ////////////////////////////////////////////////////////////////////
   // Count source and oscillator

   // Both pins cross into the core clock before any logic sees them
   two_flop_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clock(clock),
      .async_in({osc_in_pin, ext_count_input}),
      .sync_out(pins_s)
   );

   // Oscillator input replaces the count pin when enabled
   assign src_level = osc_en ? pins_s[1] : pins_s[0];

   // Inverting amplifier stand-in; keeps running while asleep
   always_ff @(posedge clock) begin
      if (rst) begin
         osc_drive_r <= 1'b0;
      end else begin
         osc_drive_r <= osc_en && !pins_s[1];
      end
   end

   // Prescaler restarts on count writes and on any reset
   assign presc_clear = rst || dev_reset || wr_count_any;

   // Prescaler keeps counting in sleep in every mode
   ripple_prescaler #(
      .STAGES(3)
   ) u_prescaler (
      .clock(clock),
      .clear(presc_clear),
      .src_level(src_level),
      .select(presc_sel),
      .presc_out(presc_out)
   );

   ////////////////////////////////////////////////////////////////////
   // Increment sources

   // Timer mode: once per instruction cycle, none while asleep
   assign inc_timer = !ext_mode && !sleep &&
                      (phase_r == tmr_pkg::FOURTH_PHASE);

   // Synced mode samples at the second and fourth phase only
   always_ff @(posedge clock) begin
      if (rst) begin
         sample_r <= 1'b0;
         sync_rise_r <= 1'b0;
      end else begin
         sync_rise_r <= 1'b0;
         if (sample_phase && !sleep) begin
            sample_r <= presc_out;
            sync_rise_r <= presc_out && !sample_r;
         end
      end
   end

   // Count lands one clock after the sampled edge
   assign inc_sync = sync_mode && sync_rise_r;

   // Unsynchronized mode: edge straight from the prescaler
   always_ff @(posedge clock) begin
      if (rst) begin
         presc_prev_r <= 1'b0;
      end else begin
         presc_prev_r <= presc_out;
      end
   end

   // Runs regardless of sleep
   assign inc_async = async_mode && presc_out && !presc_prev_r;

   // Nothing advances while the timer is off
   assign inc = timer_on && (inc_timer || inc_sync || inc_async);

   ////////////////////////////////////////////////////////////////////
   // Counter

   // Special event trigger only outside unsynchronized mode
   assign trigger_hit = !async_mode &&
      ((compare_match_one &&
        compare_mode_select_one == tmr_pkg::SPECIAL_EVENT_MODE) ||
       (compare_match_two &&
        compare_mode_select_two == tmr_pkg::SPECIAL_EVENT_MODE));

   // Write beats trigger, trigger beats increment
   always_comb begin
      count_nxt = count_r;
      if (wr_count_any) begin
         if (wr_count_lo) begin
            count_nxt[7:0] = wr_byte;
         end
         if (wr_count_hi) begin
            count_nxt[15:8] = wr_byte;
         end
      end else if (trigger_hit) begin
         count_nxt = tmr_pkg::COUNT_ZERO;
      end else if (inc) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   // Wrap is only a true increment past the top
   assign overflow_set = inc && !wr_count_any && !trigger_hit &&
                         (count_r == tmr_pkg::COUNT_MAX);

   // Count bytes carry no reset at all
   always_ff @(posedge clock) begin
      count_r <= count_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // Flags and interrupt outputs

   // Hardware set wins over a same-cycle software clear
   always_ff @(posedge clock) begin
      if (rst) begin
         peripheral_flags_r <= tmr_pkg::RST_PERIPHERAL_FLAGS;
      end else begin
         if (wr_lane0 && reg_index == tmr_pkg::IDX_PERIPHERAL_FLAGS) begin
            peripheral_flags_r <= wr_byte;
         end
         if (overflow_set) begin
            peripheral_flags_r[tmr_pkg::OVERFLOW_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // Interrupt needs the enable and both global gates
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r <= peripheral_flags_r[tmr_pkg::OVERFLOW_FLAG_BIT] &&
            peripheral_enables_r[tmr_pkg::OVERFLOW_IRQ_ENABLE_BIT] &&
            interrupt_control_r[tmr_pkg::GLOBAL_IRQ_ENABLE_BIT] &&
            interrupt_control_r[tmr_pkg::PERIPH_IRQ_ENABLE_BIT];
         // Wake ignores global gates so sleep can end
         wake_r <= sleep &&
            peripheral_flags_r[tmr_pkg::OVERFLOW_FLAG_BIT] &&
            peripheral_enables_r[tmr_pkg::OVERFLOW_IRQ_ENABLE_BIT];
      end
   end

   // Capture/compare must not lean on an unsynchronized count
   always_ff @(posedge clock) begin
      if (rst) begin
         tb_valid_r <= 1'b0;
      end else begin
         tb_valid_r <= !async_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign osc_out_pin = osc_drive_r;
   assign timebase = count_r;
   assign timebase_valid = tb_valid_r;
   assign overflow_irq = irq_r;
   assign wake_request = wake_r;

endmodule : sixteen_bit_timer_counter

// ===== verification/tmr_checker.sv
// Port-level assertions for the 16-bit timer/counter
`timescale 1ns/1ps
module tmr_checker #(
   parameter int ADDR_W = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic dev_reset,
   input wire logic sleep,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [3:0] compare_mode_select_one,
   input wire logic compare_match_one,
   input wire logic [3:0] compare_mode_select_two,
   input wire logic compare_match_two,
   input wire logic [15:0] timebase,
   input wire logic timebase_valid,
   input wire logic wake_request
);
   localparam logic [ADDR_W-1:0] A_CTL =
      ADDR_W'({tmr_pkg::IDX_TIMER_CONTROL, 2'h0});
   localparam logic [ADDR_W-1:0] A_LO =
      ADDR_W'({tmr_pkg::IDX_COUNT_LOW_BYTE, 2'h0});
   localparam logic [ADDR_W-1:0] A_HI =
      ADDR_W'({tmr_pkg::IDX_COUNT_HIGH_BYTE, 2'h0});
   logic done, wr, trig, async_m, quiet, run_t;
   logic [7:0] ctl_r;
   logic [1:0] seen_r;
   ////////////////////////////////////////////////////////////////////////
   // Decode of finished transfers, triggers and quiet cycles
   assign done = psel && penable && pready;
   assign wr = done && pwrite && pstrb[0];
   assign trig = (compare_match_one &&
      compare_mode_select_one == tmr_pkg::SPECIAL_EVENT_MODE) ||
      (compare_match_two &&
      compare_mode_select_two == tmr_pkg::SPECIAL_EVENT_MODE);
   assign async_m = ctl_r[1] && ctl_r[2];
   assign quiet = !psel && !compare_match_one && !compare_match_two &&
      !dev_reset && seen_r == 2'h3;
   assign run_t = quiet && ctl_r[1:0] == 2'h1 && !sleep;
   // Control shadow; the count is unknown until both bytes are written
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl_r <= 8'h00;
         seen_r <= 2'h0;
      end else if (wr) begin
         if (paddr == A_CTL) ctl_r <= pwdata[7:0] & 8'h3F;
         if (paddr == A_LO) seen_r[0] <= 1'b1;
         if (paddr == A_HI) seen_r[1] <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_ready_after_wait: assert property (
      psel && penable && !pready |=> pready)
      else $error("bus answer missing after one wait state");
   a_timer_step: assert property (
      run_t [*5] |-> timebase == $past(timebase, 4) + 16'h0001)
      else $error("timer mode did not step once in four clocks");
   a_off_holds: assert property (
      !ctl_r[0] && !$past(ctl_r[0]) && quiet |=> $stable(timebase))
      else $error("count moved while timer off");
   a_sleep_holds: assert property (
      sleep && $past(sleep) && !ctl_r[2] && quiet |=> $stable(timebase))
      else $error("synchronized count moved in sleep");
   a_trig_clears: assert property (
      trig && !async_m && !psel |=> timebase == 16'h0000)
      else $error("special event did not clear the count");
   a_write_wins: assert property (
      wr && paddr == A_LO |=> timebase[7:0] == $past(pwdata[7:0]))
      else $error("low byte write not stored");
   a_async_invalid: assert property (
      async_m [*2] |-> !timebase_valid)
      else $error("async count offered as time base");
   a_sync_valid: assert property (
      (!async_m) [*2] |-> timebase_valid)
      else $error("synchronized count not offered as time base");
   a_ctl_readback: assert property (
      done && !pwrite && paddr == A_CTL |-> prdata == {24'h0, ctl_r})
      else $error("control read back wrong");
   a_wake_in_sleep: assert property (
      $rose(wake_request) |-> $past(sleep))
      else $error("wake request outside sleep");
endmodule : tmr_checker

bind sixteen_bit_timer_counter tmr_checker #(.ADDR_W(ADDR_W)) i_chk (.*);

// ===== verification/count_source_model.sv
// Behavioural external count source on the count input pin
`timescale 1ns/1ps
module count_source_model #(
   parameter int HALF = 4
) (
   input wire logic clock,
   input wire logic run,
   output logic ext_count_input
);
   int cnt;
   // Levels last HALF clocks, 200 ns, well above two periods plus margin
   always_ff @(posedge clock) begin
      if (!run) begin
         cnt <= 0;
         ext_count_input <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         ext_count_input <= !ext_count_input;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : count_source_model

// ===== verification/sixteen_bit_timer_counter_tb_top.sv
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
module sixteen_bit_timer_counter_tb_top;
   localparam logic [7:0] CTL = tmr_pkg::IDX_TIMER_CONTROL;
   localparam logic [7:0] LO = tmr_pkg::IDX_COUNT_LOW_BYTE;
   localparam logic [7:0] HI = tmr_pkg::IDX_COUNT_HIGH_BYTE;
   localparam logic [7:0] FLG = tmr_pkg::IDX_PERIPHERAL_FLAGS;
   localparam logic [7:0] ENA = tmr_pkg::IDX_PERIPHERAL_ENABLES;
   // Ten source edges through each prescale; ten is no multiple of eight,
   // so a prescaler that keeps old edges across a count write shows up
   localparam logic [7:0] PRESC_EXP [4] = '{8'h0A, 8'h05, 8'h03, 8'h01};
   logic clock, rst = 1'b1, dev_reset = 1'b0, sleep = 1'b0, run = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, m1 = 1'b0, m2 = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] mode1 = 4'hB;
   logic pready, slverr, err, irq, wake, ext, osc, osc_out, trg = 1'b0;
   logic use_osc = 1'b0;
   int fail_count = 0;
   int cmp_count = 0;
   ////////////////////////////////////////////////////////////////////////
   // Second compare unit stays in special event mode throughout
   sixteen_bit_timer_counter i_dut (.clock(clock), .rst(rst),
      .dev_reset(dev_reset), .sleep(sleep), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(slverr),
      .ext_count_input(ext), .osc_in_pin(osc), .osc_out_pin(osc_out),
      .compare_mode_select_one(mode1), .compare_match_one(m1),
      .compare_mode_select_two(4'hB), .compare_match_two(m2),
      .timebase(), .timebase_valid(), .overflow_irq(irq),
      .wake_request(wake));
   count_source_model i_src (.clock(clock), .run(run && !use_osc),
      .ext_count_input(ext));
   // Second source stands in for the crystal on the oscillator pin
   count_source_model i_osc (.clock(clock), .run(run && use_osc),
      .ext_count_input(osc));
   // Clock generator
   initial begin
      clock = 1'b0;
      forever #25 clock = !clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // One APB transfer; trg pulses the first trigger in the ready cycle
   task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
      int n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         m1 <= trg && !pready;
         n++;
      end while (!pready && n < 20);
      if (!pready) begin
         fail_count++;
         finish_test();
      end
      rd = prdata;
      err = slverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(logic [7:0] idx, logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr
   task automatic rdc(string n, logic [7:0] idx, logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(n, rd, {24'h0, e});
   endtask : rdc
   // Pulses trigger one, trigger two, device reset or power-on reset
   task automatic pulse(int k);
      @(posedge clock);
      m1 <= (k == 0);
      m2 <= (k == 1);
      dev_reset <= (k == 2);
      rst <= (k == 3);
      @(posedge clock);
      m1 <= 1'b0;
      m2 <= 1'b0;
      dev_reset <= 1'b0;
      rst <= 1'b0;
   endtask : pulse
   // Source runs n clocks, then the sync pipeline gets time to settle
   task automatic ext_run(int n);
      @(posedge clock);
      run <= 1'b1;
      repeat (n) @(posedge clock);
      run <= 1'b0;
      repeat (12) @(posedge clock);
   endtask : ext_run
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rdc("ctl", CTL, 8'h00);
      chk("osc_out", {31'h0, osc_out}, 32'h0);
      rdc("flags", FLG, 8'h00);
      apb(1'b0, 8'h0D, 8'h00);
      chk("slverr", {31'h0, err}, 32'h1);
      $display("test reset done");
      wr(LO, 8'hF0);
      wr(HI, 8'hFF);
      wr(ENA, 8'h01);
      wr(tmr_pkg::IDX_INTERRUPT_CONTROL, 8'hC0);
      wr(CTL, 8'h01);
      repeat (80) @(posedge clock);
      wr(CTL, 8'h00);
      rdc("high", HI, 8'h00);
      rdc("flags", FLG, 8'h01);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(ENA, 8'h00);
      wr(LO, 8'h40);
      repeat (20) @(posedge clock);
      chk("irq", {31'h0, irq}, 32'h0);
      rdc("held", LO, 8'h40);
      wr(FLG, 8'h00);
      $display("test overflow done");
      for (int u = 0; u < 2; u++) begin
         wr(HI, 8'h12);
         wr(CTL, 8'h01);
         pulse(u);
         wr(CTL, 8'h00);
         rdc("high", HI, 8'h00);
      end
      rdc("flags", FLG, 8'h00);
      mode1 <= 4'hA;
      wr(HI, 8'h12);
      pulse(0);
      rdc("high", HI, 8'h12);
      mode1 <= 4'hB;
      trg <= 1'b1;
      wr(LO, 8'h55);
      trg <= 1'b0;
      rdc("low", LO, 8'h55);
      rdc("high", HI, 8'h12);
      $display("test trigger done");
      for (int p = 0; p < 4; p++) begin
         wr(CTL, 8'h03 | 8'(p << 4));
         ext_run(40);
         wr(LO, 8'h00);
         wr(HI, 8'h00);
         ext_run(80);
         rdc("prescale", LO, PRESC_EXP[p]);
      end
      $display("test prescale done");
      wr(LO, 8'hF8);
      wr(HI, 8'hFF);
      wr(ENA, 8'h01);
      wr(CTL, 8'h07);
      sleep <= 1'b1;
      ext_run(128);
      chk("wake", {31'h0, wake}, 32'h1);
      sleep <= 1'b0;
      rdc("async hi", HI, 8'h00);
      rdc("async", LO, 8'h08);
      rdc("reread hi", HI, 8'h00);
      wr(LO, 8'h00);
      wr(CTL, 8'h03);
      sleep <= 1'b1;
      ext_run(128);
      sleep <= 1'b0;
      rdc("sleep", LO, 8'h00);
      // Count from the crystal pin while the count pin stays idle
      use_osc <= 1'b1;
      wr(LO, 8'h00);
      wr(CTL, 8'h0B);
      repeat (20) @(posedge clock);
      ext_run(128);
      chk("osc_out", {31'h0, osc_out}, 32'h1);
      rdc("osc", LO, 8'h10);
      $display("test external done");
      wr(CTL, 8'h30);
      wr(LO, 8'hA5);
      pulse(2);
      rdc("ctl", CTL, 8'h30);
      rdc("low", LO, 8'hA5);
      pulse(3);
      rdc("ctl", CTL, 8'h00);
      rdc("low", LO, 8'hA5);
      $display("test resets done");
      finish_test();
   end
endmodule : sixteen_bit_timer_counter_tb_top
